// file: eisb_top.sv
// Interrupt event status bank: sticky event bits, enable mask, master
// interrupt and power-event wake handling behind a plain register port.
// Assumes all event inputs are synchronous to core_clk; pulse inputs are
// one cycle wide, level inputs are held by their sources.
//
// Overview of operation
// [R1] Event bits sticky; write one clears them
// [R2] Bit 31 set while software enable high
// [R3] Bit 25 on stop request with halted transmitter
// [R4] Bit 24 when receiver halts
// [R5] Bit 23 when drop counter passes halfway
// [R6] Bit 21 on flagged transmit buffer loaded
// [R7] Bit 20 when receive DMA count moved
// [R8] Bit 19 when timer wraps through zero
// [R9] Bit 18 read-only, follows transceiver source
// [R10] Bit 17 on power event, pin independent
// [R11] Only byte-test write wakes the device
// [R12] Hold-off interval never gates power event
// [R13] Bit 16 on transmit status overflow
// [R14] Bit 15 on oversize receive frame
// [R15] Bit 14 on receiver error
// [R16] Bit 13 on transmitter error
// [R17] Bit 10 on write to full data FIFO
// [R18] Bit 9 when free space exceeds threshold
// [R19] Bits 8 and 4 on status FIFOs full
// [R20] Bits 7 and 3 on status FIFO levels
// [R21] Bit 6 on every dropped frame
// [R22] Bits 2..0 latch pin events, reset zero
// [R23] Status records events regardless of enables
// [R24] Master interrupt from any enabled set bit
// [R25] Reserved bits zero; event beats clear
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "eisb_defines.svh"
module eisb_top (
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Event sources
    input wire logic tx_stop_request,
    input wire logic tx_halted,
    input wire logic rx_halted,
    input wire logic frame_dropped_event,
    input wire logic transmit_buffer_done_event,
    input wire logic completion_notify_flag,
    input wire logic receive_dma_done,
    input wire logic timer_decrement,
    input wire logic [15:0] timer_value,
    input wire logic transceiver_event,
    input wire logic power_event,
    input wire logic wake_event_pin_enable,
    input wire logic tx_status_overflow_event,
    input wire logic receive_watchdog_event,
    input wire logic receive_error_event,
    input wire logic transmit_error_event,
    input wire logic tx_data_write,
    input wire logic tx_data_full,
    input wire logic tx_data_space_event,
    input wire logic tx_status_full_event,
    input wire logic tx_status_level_event,
    input wire logic rx_status_full_event,
    input wire logic rx_status_level_event,
    input wire logic [2:0] general_pin_events,
    input wire logic sleep_request,
    // Outputs
    output logic master_irq,
    output logic power_irq,
    output logic wake_event_pin,
    output logic device_asleep
);

    eisb_pkg::eisb_state_t state;
    eisb_pkg::eisb_state_t next_state;

    logic [6:0] level_vec;
    logic [6:0] level_rise;
    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic drop_half;
    logic hit_status;
    logic hit_enable;
    logic hit_byte_test;
    logic hit_drop;

    // Level-type sources raise their bit once per assertion, so a clear while
    // the condition persists sticks until the condition returns
    assign level_vec = {tx_stop_request & tx_halted, rx_halted, tx_data_space_event,
                        tx_status_full_event, tx_status_level_event,
                        rx_status_full_event, rx_status_level_event};

    eisb_edge #(
        .WIDTH(7)
    ) u_edge (
        .core_clk(core_clk),
        .rst(rst),
        .level(level_vec),
        .rise(level_rise)
    );

    // Address decode of the register port
    assign hit_status = (reg_addr == `EISB_STATUS_OFS);
    assign hit_enable = (reg_addr == `EISB_ENABLE_OFS);
    assign hit_byte_test = (reg_addr == `EISB_BYTE_TEST_OFS);
    assign hit_drop = (reg_addr == `EISB_DROP_COUNT_OFS);

    // Halfway crossing of the dropped-frame counter
    assign drop_half = frame_dropped_event && (state.drop_count == `EISB_DROP_HALFWAY); // R5

    // Gather every event that raises a status bit this cycle
    always_comb begin
        set_vec = '0;
        set_vec[`EISB_BIT_SOFTWARE] = state.enable[`EISB_BIT_SOFTWARE]; // R2
        set_vec[`EISB_BIT_TX_HALTED] = level_rise[6]; // R3
        set_vec[`EISB_BIT_RX_HALTED] = level_rise[5]; // R4
        set_vec[`EISB_BIT_DROP_HALF] = drop_half; // R5
        set_vec[`EISB_BIT_TX_DONE] = transmit_buffer_done_event & completion_notify_flag; // R6
        set_vec[`EISB_BIT_RX_DMA] = receive_dma_done; // R7
        set_vec[`EISB_BIT_TIMER] = timer_decrement && (timer_value == `EISB_TIMER_ZERO); // R8
        // Power event is caught whatever the wake pin enable says
        set_vec[`EISB_BIT_POWER] = power_event; // R10
        set_vec[`EISB_BIT_TXS_OVF] = tx_status_overflow_event; // R13
        set_vec[`EISB_BIT_WATCHDOG] = receive_watchdog_event; // R14
        set_vec[`EISB_BIT_RX_ERR] = receive_error_event; // R15
        set_vec[`EISB_BIT_TX_ERR] = transmit_error_event; // R16
        set_vec[`EISB_BIT_TXD_OVR] = tx_data_write & tx_data_full; // R17
        set_vec[`EISB_BIT_TXD_SPACE] = level_rise[4]; // R18
        set_vec[`EISB_BIT_TXS_FULL] = level_rise[3]; // R19
        set_vec[`EISB_BIT_TXS_LEVEL] = level_rise[2]; // R20
        set_vec[`EISB_BIT_DROPPED] = frame_dropped_event; // R21
        set_vec[`EISB_BIT_RXS_FULL] = level_rise[1]; // R19
        set_vec[`EISB_BIT_RXS_LEVEL] = level_rise[0]; // R20
        set_vec[2:0] = general_pin_events; // R22
    end

    // Write-one-to-clear, only on implemented clearable bits
    assign clear_vec = (reg_wr && hit_status) ? (reg_wdata & `EISB_CLEAR_MASK) : '0; // R1

    // Next-state logic for the whole bank
    always_comb begin
        next_state = state;
        // Set wins over a clear in the same cycle, so no event is lost
        next_state.status = ((state.status & ~clear_vec) | set_vec) & `EISB_VALID_MASK; // R1 R25 R23
        // The transceiver bit mirrors its source and ignores writes
        next_state.status[`EISB_BIT_PHY] = transceiver_event; // R9
        if (reg_wr && hit_enable) begin
            next_state.enable = reg_wdata & `EISB_VALID_MASK; // R25
        end
        if (frame_dropped_event) begin
            next_state.drop_count = state.drop_count + 32'h00000001;
        end
        // A power event never wakes the device; only a byte-test write does.
        // A sleep request in the same cycle wins, as it is the hardware event
        if (sleep_request) begin
            next_state.asleep = 1'b1;
        end else if (reg_wr && hit_byte_test) begin
            next_state.asleep = 1'b0; // R11
        end
        // Read data stands in the cycle after the read strobe only
        next_state.rd_data = '0;
        if (reg_rd) begin
            if (hit_status) begin
                next_state.rd_data = state.status;
            end else if (hit_enable) begin
                next_state.rd_data = state.enable;
            end else if (hit_byte_test) begin
                next_state.rd_data = `EISB_BYTE_TEST_VALUE;
            end else if (hit_drop) begin
                next_state.rd_data = state.drop_count;
            end else begin
                next_state.rd_data = '0;
            end
        end
    end

    // State register; constants only under reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state.status <= `EISB_STATUS_RESET; // R22
            state.enable <= `EISB_ENABLE_RESET;
            state.rd_data <= '0;
            state.drop_count <= '0;
            state.asleep <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs derived from registered state
    assign reg_rdata = state.rd_data;
    // Master interrupt ignores pin enable and hold-off, which live elsewhere
    assign master_irq = |(state.status & state.enable); // R24
    // Power interrupt path bypasses any hold-off interval
    assign power_irq = state.status[`EISB_BIT_POWER] & state.enable[`EISB_BIT_POWER]; // R12
    assign wake_event_pin = state.status[`EISB_BIT_POWER] & wake_event_pin_enable;
    assign device_asleep = state.asleep;

    // Checks of the documented behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    clear_takes_effect_a: assert property ( // R1
        (reg_wr && hit_status && reg_wdata[`EISB_BIT_RX_ERR] && !receive_error_event)
        |=> !state.status[`EISB_BIT_RX_ERR])
        else $error("status bit not cleared by write of one");

    sticky_hold_a: assert property ( // R1
        (state.status[`EISB_BIT_TX_ERR] && !(reg_wr && hit_status && reg_wdata[`EISB_BIT_TX_ERR]))
        |=> state.status[`EISB_BIT_TX_ERR])
        else $error("status bit dropped without a clear");

    software_event_a: assert property ( // R2
        state.enable[`EISB_BIT_SOFTWARE] |=> state.status[`EISB_BIT_SOFTWARE])
        else $error("software bit not set while enabled");

    drop_halfway_a: assert property ( // R5
        (frame_dropped_event && state.drop_count == `EISB_DROP_HALFWAY)
        |=> state.status[`EISB_BIT_DROP_HALF] && state.drop_count[31])
        else $error("halfway crossing not recorded");

    phy_follow_a: assert property ( // R9
        1'b1 |=> state.status[`EISB_BIT_PHY] == $past(transceiver_event))
        else $error("transceiver bit does not follow its source");

    power_event_a: assert property ( // R10
        (power_event && !wake_event_pin_enable) |=> state.status[`EISB_BIT_POWER])
        else $error("power event lost with wake pin disabled");

    wake_only_write_a: assert property ( // R11
        (state.asleep && !(reg_wr && hit_byte_test)) |=> state.asleep)
        else $error("device woke without a byte-test write");

    set_wins_a: assert property ( // R25
        (receive_watchdog_event && reg_wr && hit_status && reg_wdata[`EISB_BIT_WATCHDOG])
        |=> state.status[`EISB_BIT_WATCHDOG])
        else $error("event lost against a clear");

    reserved_zero_a: assert property ( // R25
        (state.status & ~`EISB_VALID_MASK) == 32'h00000000
        && (state.enable & ~`EISB_VALID_MASK) == 32'h00000000)
        else $error("reserved bit set");

    master_irq_a: assert property ( // R24
        (state.status[`EISB_BIT_TIMER] && state.enable[`EISB_BIT_TIMER]) |-> master_irq)
        else $error("master interrupt missing for enabled bit");

    // Level sources are judged against their own last sample, not the detector
    tx_halted_a: assert property ( // R3
        (tx_stop_request && tx_halted && !$past(tx_stop_request && tx_halted))
        |=> state.status[`EISB_BIT_TX_HALTED])
        else $error("transmit halt not recorded");

    rx_halted_a: assert property ( // R4
        (rx_halted && !$past(rx_halted)) |=> state.status[`EISB_BIT_RX_HALTED])
        else $error("receive halt not recorded");

    buffer_done_a: assert property ( // R6
        (transmit_buffer_done_event && completion_notify_flag)
        |=> state.status[`EISB_BIT_TX_DONE])
        else $error("flagged buffer completion not recorded");

    dma_done_a: assert property ( // R7
        receive_dma_done |=> state.status[`EISB_BIT_RX_DMA])
        else $error("receive DMA completion not recorded");

    // Masked events must still be recorded; the mask only feeds the interrupt
    enable_ignored_a: assert property ( // R23
        (tx_status_overflow_event && !state.enable[`EISB_BIT_TXS_OVF])
        |=> state.status[`EISB_BIT_TXS_OVF])
        else $error("masked event not recorded");

    timer_wrap_a: assert property ( // R8
        (timer_decrement && timer_value == `EISB_TIMER_ZERO)
        |=> state.status[`EISB_BIT_TIMER])
        else $error("timer wrap not recorded");

    // A decrement that stops short of zero must leave the bit alone
    timer_quiet_a: assert property ( // R8
        (timer_decrement && timer_value != `EISB_TIMER_ZERO && !state.status[`EISB_BIT_TIMER])
        |=> !state.status[`EISB_BIT_TIMER])
        else $error("timer bit set without a wrap");

    power_path_a: assert property ( // R12
        (state.status[`EISB_BIT_POWER] && state.enable[`EISB_BIT_POWER]) |-> power_irq)
        else $error("power interrupt held back");

    status_overflow_a: assert property ( // R13
        tx_status_overflow_event |=> state.status[`EISB_BIT_TXS_OVF])
        else $error("transmit status overflow not recorded");

    watchdog_set_a: assert property ( // R14
        receive_watchdog_event |=> state.status[`EISB_BIT_WATCHDOG])
        else $error("receive watchdog event not recorded");

    rx_error_a: assert property ( // R15
        receive_error_event |=> state.status[`EISB_BIT_RX_ERR])
        else $error("receiver error not recorded");

    tx_error_a: assert property ( // R16
        transmit_error_event |=> state.status[`EISB_BIT_TX_ERR])
        else $error("transmitter error not recorded");

    data_overrun_a: assert property ( // R17
        (tx_data_write && tx_data_full) |=> state.status[`EISB_BIT_TXD_OVR])
        else $error("write to full data FIFO not recorded");

    data_space_a: assert property ( // R18
        (tx_data_space_event && !$past(tx_data_space_event))
        |=> state.status[`EISB_BIT_TXD_SPACE])
        else $error("data FIFO space event not recorded");

    txs_full_a: assert property ( // R19
        (tx_status_full_event && !$past(tx_status_full_event))
        |=> state.status[`EISB_BIT_TXS_FULL])
        else $error("transmit status FIFO full not recorded");

    rxs_full_a: assert property ( // R19
        (rx_status_full_event && !$past(rx_status_full_event))
        |=> state.status[`EISB_BIT_RXS_FULL])
        else $error("receive status FIFO full not recorded");

    txs_level_a: assert property ( // R20
        (tx_status_level_event && !$past(tx_status_level_event))
        |=> state.status[`EISB_BIT_TXS_LEVEL])
        else $error("transmit status FIFO level not recorded");

    rxs_level_a: assert property ( // R20
        (rx_status_level_event && !$past(rx_status_level_event))
        |=> state.status[`EISB_BIT_RXS_LEVEL])
        else $error("receive status FIFO level not recorded");

    // Every dropped frame sets its bit and advances the counter by one
    frame_drop_a: assert property ( // R21
        frame_dropped_event |=> state.status[`EISB_BIT_DROPPED]
        && state.drop_count == $past(state.drop_count) + 32'h00000001)
        else $error("dropped frame not recorded or not counted");

    pin_events_a: assert property ( // R22
        1'b1 |=> (state.status[2:0] & $past(general_pin_events)) == $past(general_pin_events))
        else $error("general pin event not recorded");

    sleep_entry_a: assert property ( // R11
        sleep_request |=> state.asleep)
        else $error("sleep request ignored");

    byte_wake_a: assert property ( // R11
        (reg_wr && hit_byte_test && !sleep_request) |=> !state.asleep)
        else $error("byte-test write did not wake the device");

    read_status_a: assert property ( // R1
        (reg_rd && hit_status) |=> reg_rdata == $past(state.status))
        else $error("status read returned a wrong word");

    read_one_cycle_a: assert property (
        (reg_rd && hit_byte_test) |=> reg_rdata == `EISB_BYTE_TEST_VALUE
        ##1 ($past(reg_rd) || reg_rdata == 32'h00000000))
        else $error("read data not in the cycle after the strobe");

endmodule : eisb_top

// file: eisb_defines.svh
// Register offsets, field positions, reset values and masks of the
// interrupt event status bank.
// Assumes an 8-bit byte address on the register port, one word per register.
`ifndef EISB_DEFINES_SVH
`define EISB_DEFINES_SVH

`define EISB_ADDR_W 8
`define EISB_STATUS_OFS 8'h58
`define EISB_ENABLE_OFS 8'h5C
`define EISB_BYTE_TEST_OFS 8'h64
`define EISB_DROP_COUNT_OFS 8'hC0

`define EISB_BYTE_TEST_VALUE 32'h87654321
`define EISB_STATUS_RESET 32'h00000000
`define EISB_ENABLE_RESET 32'h00000000

// Implemented bits of the status and enable registers
`define EISB_VALID_MASK 32'h83BFE7DF
// Status bits that a write of one may clear (all valid bits but the PHY bit)
`define EISB_CLEAR_MASK 32'h83BBE7DF

`define EISB_DROP_HALFWAY 32'h7FFFFFFF
`define EISB_TIMER_ZERO 16'h0000

`define EISB_BIT_SOFTWARE 31
`define EISB_BIT_TX_HALTED 25
`define EISB_BIT_RX_HALTED 24
`define EISB_BIT_DROP_HALF 23
`define EISB_BIT_TX_DONE 21
`define EISB_BIT_RX_DMA 20
`define EISB_BIT_TIMER 19
`define EISB_BIT_PHY 18
`define EISB_BIT_POWER 17
`define EISB_BIT_TXS_OVF 16
`define EISB_BIT_WATCHDOG 15
`define EISB_BIT_RX_ERR 14
`define EISB_BIT_TX_ERR 13
`define EISB_BIT_TXD_OVR 10
`define EISB_BIT_TXD_SPACE 9
`define EISB_BIT_TXS_FULL 8
`define EISB_BIT_TXS_LEVEL 7
`define EISB_BIT_DROPPED 6
`define EISB_BIT_RXS_FULL 4
`define EISB_BIT_RXS_LEVEL 3

`endif

// file: eisb_pkg.sv
// Types of the interrupt event status bank.
// Assumes eisb_defines.svh supplies all numeric constants.
package eisb_pkg;

    // Whole state of the bank
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] enable;
        logic [31:0] rd_data;
        logic [31:0] drop_count;
        logic asleep;
    } eisb_state_t;

    // State of the rising-edge detector
    typedef struct packed {
        logic [6:0] prev;
    } eisb_edge_state_t;

endpackage : eisb_pkg

// file: eisb_edge.sv
// Rising-edge detector for level-type event sources.
// Assumes sources are synchronous to core_clk.
`timescale 1ns/10ps
module eisb_edge #(
    parameter int WIDTH = 7
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_prev;

    // Remember last level so a steady condition raises its bit only once
    always_comb begin
        next_prev = level;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev <= '0;
        end else begin
            prev <= next_prev;
        end
    end

    assign rise = level & ~prev;

endmodule : eisb_edge

// file: eisb_host.sv
// Host processor model: master of the plain register port.
// Assumes the slave answers a read in the next cycle with no wait states.
`timescale 1ns/10ps
module eisb_host (
    input wire logic core_clk,
    input wire logic [31:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // Idle bus, strobes low from time zero
    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 32'hFFFFFFFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write; released lines are inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_addr <= ~a;
        reg_wdata <= ~d;
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read; data taken at the edge closing the answer cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_addr <= ~a;
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd
endmodule : eisb_host

// file: testbench.sv
// Self-checking bench of the interrupt event status bank.
// Assumes the host model drives the register port and the bench all event sources.
`timescale 1ns/10ps
`include "eisb_defines.svh"
module testbench;
    logic core_clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [22:0] ev;
    logic [2:0] gp;
    logic [15:0] tv;
    logic master_irq;
    logic power_irq;
    logic wake_event_pin;
    logic device_asleep;
    logic [31:0] d;
    int fails;
    int cmp_count;

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    eisb_top uut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_stop_request(ev[0]), .tx_halted(ev[1]), .rx_halted(ev[2]),
        .frame_dropped_event(ev[3]), .transmit_buffer_done_event(ev[4]),
        .completion_notify_flag(ev[5]), .receive_dma_done(ev[6]),
        .timer_decrement(ev[7]), .timer_value(tv), .transceiver_event(ev[8]),
        .power_event(ev[9]), .wake_event_pin_enable(ev[10]),
        .tx_status_overflow_event(ev[11]), .receive_watchdog_event(ev[12]),
        .receive_error_event(ev[13]), .transmit_error_event(ev[14]),
        .tx_data_write(ev[15]), .tx_data_full(ev[16]), .tx_data_space_event(ev[17]),
        .tx_status_full_event(ev[18]), .tx_status_level_event(ev[19]),
        .rx_status_full_event(ev[20]), .rx_status_level_event(ev[21]),
        .general_pin_events(gp), .sleep_request(ev[22]), .master_irq(master_irq),
        .power_irq(power_irq), .wake_event_pin(wake_event_pin),
        .device_asleep(device_asleep)
    );

    eisb_host host (
        .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // One-cycle source activity, then read, clear by writing ones, read again
    task automatic fire(input logic [22:0] m, input logic [2:0] g, input logic [31:0] e);
        @(posedge core_clk);
        ev <= m;
        gp <= g;
        @(posedge core_clk);
        ev <= 23'h000000;
        gp <= 3'h0;
        host.rd(`EISB_STATUS_OFS, d);
        chk("status", d, e);
        host.wr(`EISB_STATUS_OFS, 32'hFFFFFFFF);
        host.rd(`EISB_STATUS_OFS, d);
        chk("cleared", d, 32'h00000000);
    endtask : fire

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        fails++;
        stop_test();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        ev = 23'h000000;
        gp = 3'h0;
        tv = 16'h0005;
        fails = 0;
        cmp_count = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        host.rd(`EISB_STATUS_OFS, d);
        chk("status reset", d, `EISB_STATUS_RESET);
        host.rd(`EISB_BYTE_TEST_OFS, d);
        chk("byte test", d, `EISB_BYTE_TEST_VALUE);
        host.wr(`EISB_ENABLE_OFS, 32'hFFFFFFFF);
        host.wr(8'h60, 32'h00000000);
        host.rd(`EISB_ENABLE_OFS, d);
        chk("enable mask", d, `EISB_VALID_MASK);
        host.rd(8'h70, d);
        chk("unmapped", d, 32'h00000000);
        host.wr(`EISB_ENABLE_OFS, 32'h00000000);
        // The software bit latched while all enables were on; clear it first
        host.wr(`EISB_STATUS_OFS, 32'hFFFFFFFF);
        // Events with enables off still latch
        fire(23'h000003, 3'h0, 32'h02000000);
        fire(23'h000002, 3'h0, 32'h00000000);
        fire(23'h000004, 3'h0, 32'h01000000);
        fire(23'h000008, 3'h0, 32'h00000040);
        host.rd(`EISB_DROP_COUNT_OFS, d);
        chk("drop count", d, 32'h00000001);
        fire(23'h000030, 3'h0, 32'h00200000);
        fire(23'h000010, 3'h0, 32'h00000000);
        fire(23'h000040, 3'h0, 32'h00100000);
        fire(23'h000080, 3'h0, 32'h00000000);
        tv <= 16'h0000;
        fire(23'h000080, 3'h0, 32'h00080000);
        fire(23'h000200, 3'h0, 32'h00020000);
        fire(23'h000800, 3'h0, 32'h00010000);
        fire(23'h001000, 3'h0, 32'h00008000);
        fire(23'h002000, 3'h0, 32'h00004000);
        fire(23'h004000, 3'h0, 32'h00002000);
        fire(23'h018000, 3'h0, 32'h00000400);
        fire(23'h008000, 3'h0, 32'h00000000);
        fire(23'h020000, 3'h0, 32'h00000200);
        fire(23'h140000, 3'h0, 32'h00000110);
        fire(23'h280000, 3'h0, 32'h00000088);
        fire(23'h000000, 3'h5, 32'h00000005);
        fire(23'h000000, 3'h2, 32'h00000002);
        // Transceiver bit follows its source and ignores writes
        @(posedge core_clk);
        ev <= 23'h000100;
        host.wr(`EISB_STATUS_OFS, 32'hFFFFFFFF);
        host.rd(`EISB_STATUS_OFS, d);
        chk("phy held", d, 32'h00040000);
        ev <= 23'h000000;
        host.rd(`EISB_STATUS_OFS, d);
        chk("phy gone", d, 32'h00000000);
        // Master interrupt, and an event beating its own clear
        host.wr(`EISB_ENABLE_OFS, 32'h00004000);
        fork
            host.wr(`EISB_STATUS_OFS, 32'h00004000);
            begin
                @(posedge core_clk);
                ev <= 23'h002000;
                @(posedge core_clk);
                ev <= 23'h000000;
            end
        join
        @(posedge core_clk);
        chk("master irq", {31'h0, master_irq}, 32'h00000001);
        host.rd(`EISB_STATUS_OFS, d);
        chk("set wins", d, 32'h00004000);
        host.wr(`EISB_STATUS_OFS, 32'h00004000);
        @(posedge core_clk);
        chk("irq off", {31'h0, master_irq}, 32'h00000000);
        // Power event with pin on, then sleep that only a byte-test write ends
        host.wr(`EISB_ENABLE_OFS, 32'h00020000);
        @(posedge core_clk);
        ev <= 23'h000600;
        @(posedge core_clk);
        ev <= 23'h400400;
        @(posedge core_clk);
        ev <= 23'h000200;
        @(posedge core_clk);
        // Pin enable back on so the wake pin shows the latched power bit
        ev <= 23'h000400;
        @(posedge core_clk);
        chk("power irq", {30'h0, power_irq, wake_event_pin}, 32'h00000003);
        chk("asleep", {31'h0, device_asleep}, 32'h00000001);
        host.wr(`EISB_BYTE_TEST_OFS, 32'h00000000);
        @(posedge core_clk);
        chk("awake", {31'h0, device_asleep}, 32'h00000000);
        host.wr(`EISB_STATUS_OFS, 32'h00020000);
        // Software bit re-sets while enabled
        host.wr(`EISB_ENABLE_OFS, 32'h80000000);
        host.wr(`EISB_STATUS_OFS, 32'h80000000);
        host.rd(`EISB_STATUS_OFS, d);
        chk("software", d, 32'h80000000);
        host.wr(`EISB_ENABLE_OFS, 32'h00000000);
        host.wr(`EISB_STATUS_OFS, 32'h80000000);
        host.rd(`EISB_STATUS_OFS, d);
        chk("software off", d, 32'h00000000);
        stop_test();
    end
endmodule : testbench
